// ---- trig_pkg.sv ----
/*
 * Shared constants of the trigger and dead-time manager: register offsets,
 * control bit positions, pin indices, event type codes, timing figures and
 * the state type of the sequencer.
 * Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none
package trig_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int US_NS = 1000;
    localparam int MS_NS = 1000000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int ABORT_STEP_MS = 10;
    localparam int ABORT_STEP_CYCLES = ABORT_STEP_MS * (MS_NS / CLK_PERIOD_NS);
    localparam logic [7:0] ABORT_ROUND_MS = 8'h05;
    localparam logic [4:0] ABORT_MIN_STEPS = 5'h01;
    localparam logic [4:0] ABORT_MAX_STEPS = 5'h10;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MULT = 8'h04;
    localparam logic [7:0] OFS_DEAD = 8'h08;
    localparam logic [7:0] OFS_ABORT = 8'h0c;
    localparam logic [7:0] OFS_PERIOD = 8'h10;
    localparam logic [7:0] OFS_MAXCNT = 8'h14;
    localparam logic [7:0] OFS_LAT0 = 8'h18;
    localparam logic [7:0] OFS_LAT3 = 8'h24;
    localparam logic [7:0] OFS_SSLAT = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_EVCOUNT = 8'h30;

    // ==========================================================
    // Control register bit positions
    localparam int CB_MASTER = 0;
    localparam int CB_PER = 1;
    localparam int CB_TTL = 2;
    localparam int CB_NIM = 3;
    localparam int CB_SER = 4;
    localparam int CB_MULT = 5;
    localparam int CB_MDST = 6;
    localparam int CB_SS = 7;
    localparam int CB_ABORT = 8;
    localparam int CB_RESTART = 9;
    localparam int CTRL_W = 10;
    localparam int MULT_HI_POS = 8;

    // ==========================================================
    // Event types and pin indices
    localparam logic [1:0] TYPE_LOCAL = 2'h3;
    localparam logic [1:0] TYPE_SINGLE = 2'h2;
    localparam logic [1:0] TYPE_SS_LAT = 2'h2;
    localparam int PIN_TTL = 0;
    localparam int PIN_NIM = 1;
    localparam int PIN_START = 2;
    localparam int PIN_TRIG = 3;
    localparam int NPINS = 4;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_SS, ST_LAT, ST_READOUT, ST_RESTART, ST_EXTRA
    } state_t;
endpackage
`default_nettype wire

// ---- trigger_deadtime_manager.sv ----
/*
 * Trigger selection, latency, event typing, capture-restart generation,
 * busy / extra dead-time and readout-abort timing, with Avalon-MM registers.
 * Assumes front-end status and master-link strobes come from logic on mclk;
 * the TTL, NIM and push-button pins are asynchronous and are synchronised.
 */
// Functional notes
// - Multiplicity trigger goes to cards or external
// - Multiplicity lower bound programmable, 0 to 127
// - Multiplicity upper bound programmable, 0 to 127
// - Extra dead-time before busy release and clear
// - Extra dead-time 0 to 1023 microseconds
// - Abort timer enable; disabled never aborts
// - Abort limit 10 to 160 ms, rounded
// - Request readout abort when dead too long
// - Periodic generator with rate and event limit
// - Master may enable any trigger source mix; the trigger button is always on
// - Slave accepts only master-link triggers
// - Latency per event type, four settings
// - Local sources produce event type 11
// - Master-link triggers keep delivered event type
// - Single-shot: restart, latency, then type 10
// - Single-shot further delayed by type-two latency
// - Standalone master auto-restarts after front-ends ready, for periodic, TTL and NIM triggers
// - Slave takes restarts only from master link
// - Restart from push button or software bit
`timescale 1ns/1ps
`default_nettype none
module trigger_deadtime_manager #(
    parameter int ABORT_STEP_CYC = trig_pkg::ABORT_STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM register slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output var logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Asynchronous trigger pins
    input wire logic ttl_trig_pin,
    input wire logic nim_trig_pin,
    input wire logic start_button_pin,
    input wire logic trig_button_pin,
    // Master timing module link, decoded
    input wire logic master_trig_pulse,
    input wire logic [1:0] master_trig_type,
    input wire logic master_restart_pulse,
    // Front-end units
    input wire logic [6:0] mult_value,
    input wire logic fe_all_ready,
    input wire logic fe_all_running,
    output var logic fe_trigger,
    output var logic [1:0] fe_trig_type,
    output var logic capture_restart,
    output var logic readout_abort,
    // External device and busy
    output var logic ext_mult_trigger,
    output var logic busy_out,
    output var logic busy_clear_msg
);
    import trig_pkg::*;

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [NPINS-1:0] pin_raw, s1_q, s2_q, s3_q, pin_edge;
    assign pin_raw = {trig_button_pin, start_button_pin, nim_trig_pin, ttl_trig_pin};

    // Each pin passes two flip-flops; the third only feeds the edge detector.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign pin_edge = s2_q & ~s3_q;

    // ==========================================================
    // Register bus
    logic ack_q;
    logic rd_take, wr_take;
    logic [CTRL_W-1:0] ctrl_q;
    logic [6:0] mult_lo_q, mult_hi_q;
    logic [9:0] extra_us_q;
    logic [4:0] abort_steps_q;
    logic [31:0] period_q, maxcnt_q, ev_cnt_q;
    logic [15:0] lat_q [4];
    logic [15:0] ss_lat_q;
    logic sw_restart_q;
    logic [31:0] rd_word, wmask, wval;
    logic [7:0] abort_ms;
    logic [4:0] abort_req;
    state_t state_q;
    logic ss_pend_q, aborted_q;

    // One wait cycle: the request is taken at the second edge it is held.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign rd_take = avs_read & ack_q;
    assign wr_take = avs_write & ack_q;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_word = 32'h0;
        unique case (avs_address)
            OFS_CTRL: rd_word = {22'h0, 1'b0, ctrl_q[CTRL_W-2:0]};
            OFS_MULT: rd_word = {17'h0, mult_hi_q, 1'b0, mult_lo_q};
            OFS_DEAD: rd_word = {22'h0, extra_us_q};
            OFS_ABORT: rd_word = {24'h0, 8'(abort_steps_q * 8'(ABORT_STEP_MS))};
            OFS_PERIOD: rd_word = period_q;
            OFS_MAXCNT: rd_word = maxcnt_q;
            OFS_SSLAT: rd_word = {16'h0, ss_lat_q};
            OFS_STATUS: rd_word = {26'h0, aborted_q, ss_pend_q, busy_out, 3'(state_q)};
            OFS_EVCOUNT: rd_word = ev_cnt_q;
            default: begin
                if (avs_address >= OFS_LAT0 && avs_address <= OFS_LAT3 &&
                    avs_address[1:0] == 2'h0) begin
                    rd_word = {16'h0, lat_q[avs_address[3:2] - OFS_LAT0[3:2]]};
                end
            end
        endcase
    end

    // Requested abort time in ms rounded to the nearest 10 ms, then clamped.
    always_comb begin
        wval = (avs_writedata & wmask) | ({24'h0, abort_ms} & ~wmask);
        // Nine bits keep the rounding sum of a large request from wrapping.
        abort_req = 5'((9'(wval[7:0]) + 9'(ABORT_ROUND_MS)) / 9'(ABORT_STEP_MS));
        if (wval[31:8] != 24'h0) begin
            abort_req = ABORT_MAX_STEPS;
        end else if (abort_req < ABORT_MIN_STEPS) begin
            abort_req = ABORT_MIN_STEPS;
        end else if (abort_req > ABORT_MAX_STEPS) begin
            abort_req = ABORT_MAX_STEPS;
        end
    end
    assign abort_ms = 8'(abort_steps_q * 8'(ABORT_STEP_MS));

    // Bus handshake and read data capture.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (avs_read & ~ack_q) begin
                avs_readdata <= rd_word;
            end
        end
    end

    // Software-written settings, merged under byte enables.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= '0;
            mult_lo_q <= '0;
            mult_hi_q <= '0;
            extra_us_q <= '0;
            abort_steps_q <= ABORT_MIN_STEPS;
            period_q <= '0;
            maxcnt_q <= '0;
            lat_q <= '{default: 16'h0};
            ss_lat_q <= '0;
            sw_restart_q <= 1'b0;
        end else begin
            sw_restart_q <= 1'b0;
            if (wr_take) begin
                unique case (avs_address)
                    OFS_CTRL: begin
                        ctrl_q <= CTRL_W'((avs_writedata & wmask) | ({22'h0, ctrl_q} & ~wmask));
                        sw_restart_q <= avs_writedata[CB_RESTART] & avs_byteenable[1];
                    end
                    OFS_MULT: begin
                        if (avs_byteenable[0]) mult_lo_q <= avs_writedata[6:0];
                        if (avs_byteenable[1]) mult_hi_q <= avs_writedata[MULT_HI_POS +: 7];
                    end
                    OFS_DEAD: begin
                        extra_us_q <= 10'((avs_writedata & wmask) | ({22'h0, extra_us_q} & ~wmask));
                    end
                    OFS_ABORT: abort_steps_q <= abort_req;
                    OFS_PERIOD: period_q <= (avs_writedata & wmask) | (period_q & ~wmask);
                    OFS_MAXCNT: maxcnt_q <= (avs_writedata & wmask) | (maxcnt_q & ~wmask);
                    OFS_SSLAT: ss_lat_q <= 16'((avs_writedata & wmask) | ({16'h0, ss_lat_q} & ~wmask));
                    default: begin
                        if (avs_address >= OFS_LAT0 && avs_address <= OFS_LAT3 &&
                            avs_address[1:0] == 2'h0) begin
                            lat_q[avs_address[3:2] - OFS_LAT0[3:2]] <= 16'((avs_writedata & wmask) |
                                ({16'h0, lat_q[avs_address[3:2] - OFS_LAT0[3:2]]} & ~wmask));
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Trigger sources
    logic master_m;
    logic per_tick, per_fire, mult_in, mult_prev_q, mult_fire;
    logic local_evt, auto_src, ser_evt, restart_evt, idle;
    logic [31:0] per_cnt_q;
    assign master_m = ctrl_q[CB_MASTER];
    assign idle = state_q == ST_IDLE;

    // Periodic generator: one tick per period, stopped at the event limit.
    assign per_tick = per_cnt_q >= period_q;
    assign per_fire = per_tick & ctrl_q[CB_PER] &
                      (maxcnt_q == 32'h0 || ev_cnt_q < maxcnt_q);
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            per_cnt_q <= '0;
            ev_cnt_q <= '0;
        end else if (!ctrl_q[CB_PER] || !master_m) begin
            per_cnt_q <= '0;
            ev_cnt_q <= '0;
        end else begin
            per_cnt_q <= per_tick ? 32'h0 : per_cnt_q + 32'h1;
            if (per_fire) begin
                ev_cnt_q <= ev_cnt_q + 32'h1;
            end
        end
    end

    // Window comparator fires once on entering the open window.
    assign mult_in = (mult_value > mult_lo_q) && (mult_value < mult_hi_q);
    assign mult_fire = mult_in & ~mult_prev_q & ctrl_q[CB_MULT] & master_m;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mult_prev_q <= 1'b0;
        end else begin
            mult_prev_q <= mult_in;
        end
    end

    // Master mode mixes any enabled source; slave mode keeps only the link.
    assign local_evt = master_m & (per_fire | (pin_edge[PIN_TTL] & ctrl_q[CB_TTL]) |
                       (pin_edge[PIN_NIM] & ctrl_q[CB_NIM]) | pin_edge[PIN_TRIG] |
                       (mult_fire & ~ctrl_q[CB_MDST]));
    assign auto_src = per_fire | (pin_edge[PIN_TTL] & ctrl_q[CB_TTL]) |
                      (pin_edge[PIN_NIM] & ctrl_q[CB_NIM]);
    assign ser_evt = master_trig_pulse & (ctrl_q[CB_SER] | ~master_m);
    assign restart_evt = master_m ? (sw_restart_q | pin_edge[PIN_START])
                                  : master_restart_pulse;

    // Multiplicity trigger routed to the external device when selected.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ext_mult_trigger <= 1'b0;
        end else begin
            ext_mult_trigger <= mult_fire & ctrl_q[CB_MDST] & idle;
        end
    end

    // ==========================================================
    // Sequencer: latency, readout, restart, extra dead-time
    logic [31:0] cnt_q;
    logic auto_q, seen_q, auto_restart;
    assign auto_restart = state_q == ST_READOUT && fe_all_ready && auto_q && master_m;
    assign busy_out = state_q inside {ST_LAT, ST_READOUT, ST_RESTART, ST_EXTRA};

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            auto_q <= 1'b0;
            seen_q <= 1'b0;
            ss_pend_q <= 1'b0;
            fe_trigger <= 1'b0;
            fe_trig_type <= 2'h0;
            capture_restart <= 1'b0;
            busy_clear_msg <= 1'b0;
        end else begin
            fe_trigger <= 1'b0;
            busy_clear_msg <= 1'b0;
            capture_restart <= restart_evt | auto_restart;
            // A user restart in single-shot mode arms one self-trigger.
            if (restart_evt && master_m && ctrl_q[CB_SS]) begin
                ss_pend_q <= 1'b1;
            end
            unique case (state_q)
                ST_IDLE: begin
                    // Triggers are taken only here, so busy hides them.
                    if (ser_evt) begin
                        state_q <= ST_LAT;
                        fe_trig_type <= master_trig_type;
                        cnt_q <= {16'h0, lat_q[master_trig_type]};
                        auto_q <= 1'b0;
                    end else if (local_evt) begin
                        state_q <= ST_LAT;
                        fe_trig_type <= TYPE_LOCAL;
                        cnt_q <= {16'h0, lat_q[TYPE_LOCAL]};
                        auto_q <= auto_src;
                    end else if (ss_pend_q && master_m && ctrl_q[CB_SS]) begin
                        state_q <= ST_SS;
                        cnt_q <= {16'h0, ss_lat_q};
                        ss_pend_q <= 1'b0;
                    end
                end
                ST_SS: begin
                    if (cnt_q == 32'h0) begin
                        state_q <= ST_LAT;
                        fe_trig_type <= TYPE_SINGLE;
                        cnt_q <= {16'h0, lat_q[TYPE_SS_LAT]};
                        auto_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_LAT: begin
                    if (cnt_q == 32'h0) begin
                        fe_trigger <= 1'b1;
                        state_q <= ST_READOUT;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_READOUT: begin
                    if (fe_all_ready) begin
                        state_q <= ST_RESTART;
                        seen_q <= auto_restart | restart_evt;
                    end
                end
                ST_RESTART: begin
                    // Wait for a restart, then for all capture writing to run.
                    if (restart_evt) begin
                        seen_q <= 1'b1;
                    end
                    if (seen_q && fe_all_running) begin
                        state_q <= ST_EXTRA;
                        cnt_q <= 32'(extra_us_q) * 32'(US_CYCLES);
                    end
                end
                ST_EXTRA: begin
                    if (cnt_q == 32'h0) begin
                        state_q <= ST_IDLE;
                        busy_clear_msg <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Readout abort timer over the dead time
    logic [31:0] step_pre_q;
    logic [4:0] step_cnt_q;
    logic step_tick;
    assign step_tick = step_pre_q == 32'(ABORT_STEP_CYC - 1);

    // Counts 10 ms steps while busy and fires one abort at the limit.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            step_pre_q <= '0;
            step_cnt_q <= '0;
            aborted_q <= 1'b0;
            readout_abort <= 1'b0;
        end else begin
            readout_abort <= 1'b0;
            if (!busy_out) begin
                step_pre_q <= '0;
                step_cnt_q <= '0;
                aborted_q <= 1'b0;
            end else begin
                step_pre_q <= step_tick ? 32'h0 : step_pre_q + 32'h1;
                if (step_tick && step_cnt_q < ABORT_MAX_STEPS) begin
                    step_cnt_q <= step_cnt_q + 5'h1;
                end
                if (ctrl_q[CB_ABORT] && !aborted_q && step_cnt_q >= abort_steps_q) begin
                    readout_abort <= 1'b1;
                    aborted_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence extra_end_s;
        state_q == ST_EXTRA ##1 state_q == ST_IDLE;
    endsequence
    sequence ss_issue_s;
        state_q == ST_SS ##1 state_q == ST_LAT;
    endsequence

    mult_window_a: assert property (mult_fire |-> mult_value > mult_lo_q && mult_value < mult_hi_q)
        else $error("Multiplicity trigger outside window.");
    mult_dest_a: assert property (ext_mult_trigger |-> $past(ctrl_q[CB_MDST]) && $past(mult_fire))
        else $error("External multiplicity trigger without selection.");
    slave_source_a: assert property (idle && !master_m && $past(idle) ##1 state_q == ST_LAT |-> $past(master_trig_pulse))
        else $error("Slave accepted a non-link trigger.");
    local_type_a: assert property (idle && !ser_evt && local_evt |=> fe_trig_type == TYPE_LOCAL && state_q == ST_LAT)
        else $error("Local trigger has wrong type.");
    busy_ignore_a: assert property (busy_out && (local_evt || ser_evt) |=> state_q != ST_IDLE || busy_clear_msg)
        else $error("Trigger accepted while busy.");
    busy_release_a: assert property (extra_end_s |-> busy_clear_msg && !busy_out)
        else $error("Busy released without clear message.");
    abort_off_a: assert property (readout_abort |-> $past(ctrl_q[CB_ABORT]) && $past(busy_out))
        else $error("Abort issued while disabled or idle.");
    slave_restart_a: assert property (capture_restart && !$past(master_m) |-> $past(master_restart_pulse))
        else $error("Slave generated a local restart.");
    ss_type_a: assert property (ss_issue_s |-> fe_trig_type == TYPE_SINGLE && cnt_q == {16'h0, $past(lat_q[TYPE_SS_LAT])})
        else $error("Single-shot trigger type or latency wrong.");
endmodule
`default_nettype wire

// ---- fe_model.sv ----
/*
 * Front-end unit model: ends readout a set delay after each trigger and
 * restarts capture writing on each capture-restart pulse.
 * Assumes single-cycle strobes from the manager on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module fe_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // From the manager and the bench
    input wire logic fe_trigger,
    input wire logic capture_restart,
    input wire logic [15:0] ready_delay,
    // To the manager
    output var logic fe_all_ready,
    output var logic fe_all_running
);
    // ==========================================================
    // Readout timer; ready stays up until the next restart.
    logic [15:0] cnt_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= 16'h0;
            fe_all_ready <= 1'b0;
            fe_all_running <= 1'b1;
        end else if (fe_trigger) begin
            cnt_q <= ready_delay;
            fe_all_ready <= 1'b0;
            fe_all_running <= 1'b0;
        end else if (capture_restart) begin
            fe_all_ready <= 1'b0;
            fe_all_running <= 1'b1;
        end else if (cnt_q != 16'h0) begin
            cnt_q <= cnt_q - 16'h1;
            fe_all_ready <= (cnt_q == 16'h1);
        end
    end
endmodule
`default_nettype wire

// ---- test_trigger_deadtime_manager.sv ----
/*
 * Self-checking bench of the trigger and dead-time manager.
 * Assumes the front-end model and a shortened abort step of 20 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module test_trigger_deadtime_manager;
    import trig_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic avs_read, avs_write, avs_waitrequest, ttl_trig_pin, nim_trig_pin;
    logic start_button_pin, trig_button_pin, master_trig_pulse, master_restart_pulse;
    logic fe_all_ready, fe_all_running, fe_trigger, capture_restart, readout_abort;
    logic ext_mult_trigger, busy_out, busy_clear_msg;
    logic [1:0] master_trig_type, fe_trig_type;
    logic [6:0] mult_value;
    logic [15:0] ready_delay;
    int n_mismatch, checked, n_trig, n_abort, n_rst;
    trigger_deadtime_manager #(.ABORT_STEP_CYC(20)) dut (.*);
    fe_model fe (.*);
    // ==========================================================
    // Clock and pulse counters.
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        n_trig += (fe_trigger === 1'b1);
        n_abort += (readout_abort === 1'b1);
        n_rst += (capture_restart === 1'b1);
    end
    // ==========================================================
    // Shared tasks.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Looks at waitrequest between edges; the request completes, and read data
    // is taken, at the next rising edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin @(negedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin n_mismatch++; finish_test(); end
        @(posedge mclk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    // Bounded wait until a counter or flag reaches its target.
    task automatic wait_on(input int sel, input int target);
        int n;
        n = 0;
        while (((sel == 0) ? n_trig : (sel == 1) ? n_abort : (sel == 2) ? n_rst
                : int'(busy_out === 1'b0)) < target && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 3000) begin n_mismatch++; finish_test(); end
    endtask
    task automatic pulse_ttl;
        ttl_trig_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        ttl_trig_pin <= 1'b0;
        @(posedge mclk);
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_regs;
        logic [31:0] wv [4] = '{32'h0, 32'hf, 32'hc8, 32'h40};
        logic [31:0] ev [4] = '{32'ha, 32'h14, 32'ha0, 32'h3c};
        bus(0, OFS_ABORT, 0);
        check("abort reset", q, 32'ha);
        for (int i = 0; i < 4; i++) begin
            bus(1, OFS_ABORT, wv[i]);
            bus(0, OFS_ABORT, 0);
            check("abort rounded", q, ev[i]);
        end
        bus(1, OFS_DEAD, 32'hfff);
        bus(0, OFS_DEAD, 0);
        check("dead range", q, 32'h3ff);
        bus(1, OFS_MULT, 32'hffff);
        bus(0, OFS_MULT, 0);
        check("mult bounds", q, 32'h7f7f);
        bus(0, 8'h3c, 0);
        check("unmapped", q, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_slave;
        bus(1, OFS_CTRL, 32'h100);
        bus(1, OFS_ABORT, 32'ha);
        bus(1, OFS_DEAD, 32'h0);
        bus(1, OFS_LAT0 + 8'h4, 32'h0);
        ready_delay <= 16'd200;
        pulse_ttl();
        repeat (20) @(posedge mclk);
        check("slave ttl", n_trig, 0);
        master_trig_type <= 2'h1;
        master_trig_pulse <= 1'b1;
        @(posedge mclk);
        master_trig_pulse <= 1'b0;
        wait_on(0, 1);
        check("link type", fe_trig_type, 2'h1);
        wait_on(1, 1);
        repeat (220) @(posedge mclk);
        check("abort count", n_abort, 1);
        check("slave restart", n_rst, 0);
        master_restart_pulse <= 1'b1;
        @(posedge mclk);
        master_restart_pulse <= 1'b0;
        wait_on(3, 1);
        $display("test slave done");
    endtask
    task automatic t_master;
        int n;
        bus(1, OFS_CTRL, 32'h5);
        bus(1, OFS_DEAD, 32'h2);
        bus(1, OFS_LAT3, 32'h0);
        ready_delay <= 16'd100;
        pulse_ttl();
        wait_on(0, 2);
        check("local type", fe_trig_type, TYPE_LOCAL);
        pulse_ttl();
        wait_on(2, 2);
        n = 0;
        while (busy_clear_msg !== 1'b1 && n < 1000) begin @(negedge mclk); n++; end
        check("extra dead", (n >= 398 && n <= 404), 1);
        check("busy drop", busy_out, 0);
        check("busy ignore", n_trig, 2);
        check("abort off", n_abort, 1);
        $display("test master done");
    endtask
    // Multiplicity window to both targets, then one single-shot event.
    task automatic t_self;
        int n;
        bus(1, OFS_MULT, 32'h0a02);
        bus(1, OFS_CTRL, 32'h61);
        mult_value <= 7'h05;
        n = 0;
        while (ext_mult_trigger !== 1'b1 && n < 20) begin @(negedge mclk); n++; end
        check("mult external", ext_mult_trigger, 1);
        check("mult not local", n_trig, 2);
        @(posedge mclk);
        mult_value <= 7'h0a;
        bus(1, OFS_CTRL, 32'h21);
        mult_value <= 7'h09;
        wait_on(0, 3);
        check("mult to cards", fe_trig_type, TYPE_LOCAL);
        repeat (120) @(posedge mclk);
        mult_value <= 7'h00;
        bus(1, OFS_CTRL, 32'h281);
        wait_on(0, 4);
        check("single type", fe_trig_type, 2'h2);
        repeat (150) @(posedge mclk);
        check("single no restart", n_rst, 3);
        check("single busy", busy_out, 1);
        $display("test self done");
    endtask
    initial begin
        {avs_read, avs_write, ttl_trig_pin, nim_trig_pin, start_button_pin} = '0;
        {trig_button_pin, master_trig_pulse, master_restart_pulse} = '0;
        {avs_address, avs_writedata, master_trig_type, mult_value} = '0;
        avs_byteenable = 4'hf;
        ready_delay = 16'h0;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_slave();
        t_master();
        t_self();
        finish_test();
    end
endmodule
`default_nettype wire
